// ---- design/prr_pkg.sv ----
// Shared constants, register map and helpers of the PLL ratio and reset release block
package prr_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 100;
  localparam int CLK_SYS_PERIOD_NS = 1000 / CLK_SYS_MHZ;
  localparam int REF_HOLD_CYCLES = 4096;
  localparam int CORE_HOLD_CORE_CLOCK = 2;
  localparam int T_CORE_CLOCK_MAX_NS = 10;
  // Two slowest core periods, rounded up to system cycles
  localparam int CORE_HOLD_SYS =
    (CORE_HOLD_CORE_CLOCK * T_CORE_CLOCK_MAX_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
  localparam int REF_CNT_W = 13;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK_STAT = 8'h04;
  // power_mgmt_control fields
  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_MULT_W = 6;
  localparam int CTRL_PDIV_LSB = 6;
  localparam int CTRL_INPUT_DIVIDE_SELECT_BIT = 8;
  // clock status fields
  localparam int STAT_VCO_LSB = 0;
  localparam int STAT_PDIV_LSB = 8;
  localparam int STAT_RUN_BIT = 12;
  localparam int STAT_PINS_LSB = 13;

  // ---------------------------------------------------------------
  // Reset values and strap table
  // ---------------------------------------------------------------
  localparam logic [5:0] STRAP_MULT_0 = 6'h08;
  localparam logic [5:0] STRAP_MULT_1 = 6'h10;
  localparam logic [5:0] STRAP_MULT_2 = 6'h20;
  localparam logic [5:0] STRAP_MULT_3 = 6'h10;
  localparam logic [1:0] RST_PDIV_SEL = 2'h0;
  localparam logic RST_INPUT_DIVIDE_SELECT = 1'b0;

  // Reset release sequence, one-hot
  typedef enum logic [2:0] {
    PRR_ST_HOLD = 3'b001,
    PRR_ST_CORE = 3'b010,
    PRR_ST_RUN = 3'b100
  } prr_state_t;

  // Multiplier chosen by the ratio straps
  function automatic logic [5:0] strap_mult(input logic [1:0] pins);
    case (pins)
      2'h0: strap_mult = STRAP_MULT_0;
      2'h1: strap_mult = STRAP_MULT_1;
      2'h2: strap_mult = STRAP_MULT_2;
      default: strap_mult = STRAP_MULT_3;
    endcase
  endfunction

  // Post divider value 1, 2, 4 or 8
  function automatic logic [3:0] pdiv_value(input logic [1:0] sel);
    pdiv_value = 4'h1 << sel;
  endfunction
endpackage

// ---- design/prr_sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module prr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- design/prr_pll_reset.sv ----
// PLL ratio control and core reset release with Wishbone registers
`timescale 1ns/100ps
`default_nettype none
module prr_pll_reset #(
  parameter int REF_HOLD = prr_pkg::REF_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reference_clock_in,
  input wire logic [1:0] clock_ratio_select_pins,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic core_rst_n,
  output logic [5:0] pll_multiplier,
  output logic [3:0] pll_post_divider,
  output logic input_divide_select,
  output logic [1:0] pll_input_div,
  output logic [6:0] vco_mult,
  output logic [4:0] core_div,
  output logic [5:0] periph_div
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic ref_s;
  logic ref_d_ff;
  logic [1:0] pins_s;
  logic ref_rise;
  logic [2:0] ref_arm_ff;

  prr_sync2 #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({reference_clock_in, clock_ratio_select_pins}),
    .q({ref_s, pins_s})
  );

  // Reference edge detect on the synchronised level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_d_ff <= 1'b0;
      ref_arm_ff <= 3'h0;
    end else begin
      ref_d_ff <= ref_s;
      ref_arm_ff <= {ref_arm_ff[1:0], 1'b1}; // Fills once real samples arrive
    end
  end
  // Synchroniser reset zeros would fake a rise if the pin is high at release
  assign ref_rise = ref_s & ~ref_d_ff & ref_arm_ff[2];

  // ---------------------------------------------------------------
  // Core reset release sequence
  // ---------------------------------------------------------------
  prr_pkg::prr_state_t state_ff;
  logic [prr_pkg::REF_CNT_W-1:0] ref_cnt_ff;
  logic [1:0] core_cnt_ff;
  localparam logic [prr_pkg::REF_CNT_W-1:0] REF_LAST = REF_HOLD[prr_pkg::REF_CNT_W-1:0];
  localparam logic [1:0] CORE_LAST = prr_pkg::CORE_HOLD_SYS[1:0];

  // Count reference edges, then two core periods
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= prr_pkg::PRR_ST_HOLD;
      ref_cnt_ff <= '0;
      core_cnt_ff <= 2'h0;
      core_rst_n <= 1'b0;
    end else begin
      case (state_ff)
        prr_pkg::PRR_ST_HOLD: begin
          if (ref_rise) begin
            ref_cnt_ff <= ref_cnt_ff + 1'b1;
            if (ref_cnt_ff + 1'b1 == REF_LAST) begin
              state_ff <= prr_pkg::PRR_ST_CORE;
            end
          end
        end
        prr_pkg::PRR_ST_CORE: begin
          core_cnt_ff <= core_cnt_ff + 1'b1;
          if (core_cnt_ff + 1'b1 == CORE_LAST) begin
            state_ff <= prr_pkg::PRR_ST_RUN;
            core_rst_n <= 1'b1;
          end
        end
        prr_pkg::PRR_ST_RUN: begin
          core_rst_n <= 1'b1;
        end
        default: begin
          state_ff <= prr_pkg::PRR_ST_HOLD;
          core_rst_n <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic req;
  logic wr_ctrl;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Control writes are ignored until the core leaves reset
  assign wr_ctrl = req & wb_we_i & (wb_adr_i == prr_pkg::ADDR_PWR_CTRL) & core_rst_n;

  // Ack one cycle after the request, dropped the next
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          prr_pkg::ADDR_PWR_CTRL: wb_dat_o <= ctrl_word;
          prr_pkg::ADDR_CLK_STAT: wb_dat_o <= stat_word;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // PLL control fields and derived ratios
  // ---------------------------------------------------------------
  logic [1:0] pdiv_sel_ff;
  logic [5:0] nxt_mult;
  logic [1:0] nxt_pdiv_sel;
  logic nxt_input_divide_select;
  logic [3:0] nxt_pdiv;

  // Straps steer the multiplier in reset, the post divider select is reset, input divide select holds; software afterwards
  always_comb begin
    nxt_mult = pll_multiplier;
    nxt_pdiv_sel = pdiv_sel_ff;
    nxt_input_divide_select = input_divide_select;
    if (!core_rst_n) begin
      nxt_mult = prr_pkg::strap_mult(pins_s);
      nxt_pdiv_sel = prr_pkg::RST_PDIV_SEL;
    end else if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        nxt_mult = wb_dat_i[prr_pkg::CTRL_MULT_LSB +: prr_pkg::CTRL_MULT_W];
        nxt_pdiv_sel = wb_dat_i[prr_pkg::CTRL_PDIV_LSB +: 2];
      end
      if (wb_sel_i[1]) begin
        nxt_input_divide_select = wb_dat_i[prr_pkg::CTRL_INPUT_DIVIDE_SELECT_BIT];
      end
    end
    nxt_pdiv = prr_pkg::pdiv_value(nxt_pdiv_sel);
  end

  // Fields and ratio words registered together
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pll_multiplier <= prr_pkg::STRAP_MULT_0;
      pdiv_sel_ff <= prr_pkg::RST_PDIV_SEL;
      input_divide_select <= prr_pkg::RST_INPUT_DIVIDE_SELECT;
      pll_post_divider <= 4'h1;
      pll_input_div <= 2'h1;
      vco_mult <= 7'h10;
      core_div <= 5'h02;
      periph_div <= 6'h04;
    end else begin
      pll_multiplier <= nxt_mult;
      pdiv_sel_ff <= nxt_pdiv_sel;
      input_divide_select <= nxt_input_divide_select;
      pll_post_divider <= nxt_pdiv;
      pll_input_div <= nxt_input_divide_select ? 2'h2 : 2'h1;
      vco_mult <= {nxt_mult, 1'b0};
      core_div <= {nxt_pdiv, 1'b0};
      periph_div <= {nxt_pdiv, 2'b00};
    end
  end

  // Register images
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[prr_pkg::CTRL_MULT_LSB +: prr_pkg::CTRL_MULT_W] = pll_multiplier;
    ctrl_word[prr_pkg::CTRL_PDIV_LSB +: 2] = pdiv_sel_ff;
    ctrl_word[prr_pkg::CTRL_INPUT_DIVIDE_SELECT_BIT] = input_divide_select;
    stat_word = 32'h0000_0000;
    stat_word[prr_pkg::STAT_VCO_LSB +: 7] = vco_mult;
    stat_word[prr_pkg::STAT_PDIV_LSB +: 4] = pll_post_divider;
    stat_word[prr_pkg::STAT_RUN_BIT] = core_rst_n;
    stat_word[prr_pkg::STAT_PINS_LSB +: 2] = pins_s;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_strap_load;
    @(posedge clk_sys) disable iff (!nrst)
      !core_rst_n |=> (pll_multiplier == prr_pkg::strap_mult($past(pins_s)));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("multiplier not from straps");

  property p_pdiv_reset;
    @(posedge clk_sys) disable iff (!nrst)
      $past(!core_rst_n) |-> (pll_post_divider == 4'h1);
  endproperty
  a_pdiv_reset: assert property (p_pdiv_reset) else $error("post divider not one");

  property p_input_div;
    @(posedge clk_sys) disable iff (!nrst)
      pll_input_div == (input_divide_select ? 2'h2 : 2'h1);
  endproperty
  a_input_div: assert property (p_input_div) else $error("input divide wrong");

  property p_vco;
    @(posedge clk_sys) disable iff (!nrst)
      vco_mult == {1'b0, pll_multiplier} * 7'h02;
  endproperty
  a_vco: assert property (p_vco) else $error("oscillator ratio wrong");

  property p_core_div;
    @(posedge clk_sys) disable iff (!nrst)
      core_div == {1'b0, prr_pkg::pdiv_value(pdiv_sel_ff)} * 5'h02;
  endproperty
  a_core_div: assert property (p_core_div) else $error("core divide wrong");

  property p_periph;
    @(posedge clk_sys) disable iff (!nrst)
      periph_div == {core_div, 1'b0};
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral divide wrong");

  property p_release_count;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(core_rst_n) |-> (ref_cnt_ff == REF_LAST) && ($past(state_ff, 2) == prr_pkg::PRR_ST_CORE);
  endproperty
  a_release_count: assert property (p_release_count) else $error("early core release");

  property p_core_wait;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(state_ff == prr_pkg::PRR_ST_CORE) |-> !core_rst_n [*2] ##1 core_rst_n;
  endproperty
  a_core_wait: assert property (p_core_wait) else $error("core wait not two cycles");

  property p_hold_low;
    @(posedge clk_sys) disable iff (!nrst)
      (state_ff == prr_pkg::PRR_ST_HOLD) |-> !core_rst_n;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("core out of reset while counting");

  property p_sw_write;
    @(posedge clk_sys) disable iff (!nrst)
      wr_ctrl && wb_sel_i[0] |=> (pll_multiplier == $past(wb_dat_i[5:0]));
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("multiplier write lost");

  c_release: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(core_rst_n));
  c_sw_write: cover property (@(posedge clk_sys) disable iff (!nrst) wr_ctrl);
  c_input_divide_select: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(input_divide_select));
endmodule
`default_nettype wire

// ---- tb/prr_board_model.sv ----
// Board-side model driving reset, ratio straps and the reference clock
`timescale 1ns/100ps
`default_nettype none
module prr_board_model #(
  parameter int SETUP_REF = 8
) (
  input wire logic clk_sys,
  input wire logic rst_req,
  input wire logic [1:0] strap_req,
  output logic nrst,
  output logic reference_clock_in,
  output logic [1:0] clock_ratio_select_pins
);
  logic ref_q;
  int held;
  initial begin
    nrst = 1'b0;
    reference_clock_in = 1'b0;
    clock_ratio_select_pins = 2'h0;
    ref_q = 1'b0;
    held = 0;
  end
  // ---------------------------------------------------------------
  // Reference clock, free running from time zero
  // ---------------------------------------------------------------
  always #20 reference_clock_in = ~reference_clock_in;
  // Straps move only in reset; release waits for enough stable ref edges
  always @(posedge clk_sys) begin
    ref_q <= reference_clock_in;
    if (rst_req) begin
      nrst <= 1'b0;
      clock_ratio_select_pins <= strap_req;
    end
    if (nrst || (rst_req && clock_ratio_select_pins != strap_req)) begin
      held <= 0;
    end else if (reference_clock_in && !ref_q) begin
      held <= held + 1;
    end
    if (!rst_req && !nrst && held >= SETUP_REF) begin
      nrst <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench of the PLL ratio and reset release block
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int HOLD = 16;
  logic clk_sys = 1'b0;
  logic rst_req = 1'b1;
  logic [1:0] strap_req = 2'h0;
  logic nrst, reference_clock_in, wb_ack_o, core_rst_n, input_divide_select;
  logic [1:0] clock_ratio_select_pins, pll_input_div;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0, pll_post_divider;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
  logic [5:0] pll_multiplier, periph_div, m;
  logic [6:0] vco_mult;
  logic [4:0] core_div;
  logic [3:0] pd;
  logic [5:0] strap_tab [0:3];
  int fail_count = 0;
  int checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  prr_board_model board (.clk_sys(clk_sys), .rst_req(rst_req), .strap_req(strap_req),
    .nrst(nrst), .reference_clock_in(reference_clock_in),
    .clock_ratio_select_pins(clock_ratio_select_pins));
  prr_pll_reset #(.REF_HOLD(HOLD)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .reference_clock_in(reference_clock_in), .clock_ratio_select_pins(clock_ratio_select_pins),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_rst_n(core_rst_n),
    .pll_multiplier(pll_multiplier), .pll_post_divider(pll_post_divider),
    .input_divide_select(input_divide_select), .pll_input_div(pll_input_div),
    .vco_mult(vco_mult), .core_div(core_div), .periph_div(periph_div));
  // ---------------------------------------------------------------
  // Bus cycle, compare and closing tasks
  // ---------------------------------------------------------------
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) fail_count++;
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_in(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic test_done;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset with given straps; count ref edges until core release, or abort midway
  task automatic do_reset(input logic [1:0] s, input logic abort);
    int refs;
    int n;
    logic rq;
    rst_req <= 1'b1;
    strap_req <= s;
    repeat (3) @(posedge clk_sys);
    check_eq(pll_post_divider, 4'h1);
    check_eq(core_rst_n, 1'b0);
    repeat (3) @(posedge clk_sys);
    rst_req <= 1'b0;
    n = 0;
    while (nrst !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    refs = 0;
    rq = reference_clock_in;
    while (core_rst_n !== 1'b1 && n < 2000 && !(abort && refs >= HOLD / 2)) begin
      @(posedge clk_sys);
      n++;
      if (reference_clock_in && !rq) refs++;
      rq = reference_clock_in;
    end
    if (!abort) begin
      check_eq(core_rst_n, 1'b1);
      check_in(refs, HOLD, HOLD + 2);
      check_eq(pll_multiplier, strap_tab[s]);
    end else begin
      check_eq(core_rst_n, 1'b0);
      wb_xfer(1'b1, prr_pkg::ADDR_PWR_CTRL, 32'h0000_01FF, q);
      check_eq(pll_multiplier, strap_tab[s]);
      check_eq(pll_post_divider, 4'h1);
    end
  endtask
  // Watchdog against a hung handshake or release
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    strap_tab = '{prr_pkg::STRAP_MULT_0, prr_pkg::STRAP_MULT_1, prr_pkg::STRAP_MULT_2,
                  prr_pkg::STRAP_MULT_3};
    for (int s = 0; s < 4; s++) do_reset(s[1:0], 1'b0);
    do_reset(2'h1, 1'b1);
    do_reset(2'h1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      m = 6'h04 + 6'(i);
      pd = 4'h1 << i[1:0];
      wb_xfer(1'b1, prr_pkg::ADDR_PWR_CTRL, {23'h0, i[2], i[1:0], m}, q);
      check_eq(pll_multiplier, m);
      check_eq(pll_post_divider, pd);
      check_eq(input_divide_select, i[2]);
      check_eq(pll_input_div, {i[2], ~i[2]});
      check_eq(vco_mult, {m, 1'b0});
      check_eq(core_div, {pd, 1'b0});
      check_eq(periph_div, {pd, 2'b00});
      wb_xfer(1'b0, prr_pkg::ADDR_PWR_CTRL, 32'h0, q);
      check_eq(q, {23'h0, i[2], i[1:0], m});
      wb_xfer(1'b0, prr_pkg::ADDR_CLK_STAT, 32'h0, q);
      check_eq(q[6:0], {m, 1'b0});
      check_eq(q[14:8], {2'h1, 1'b1, pd});
    end
    wb_xfer(1'b0, 8'h08, 32'h0, q);
    check_eq(q, 32'h0);
    wb_xfer(1'b1, prr_pkg::ADDR_CLK_STAT, 32'hFFFF_FFFF, q);
    wb_xfer(1'b0, prr_pkg::ADDR_PWR_CTRL, 32'h0, q);
    check_eq(q, 32'h0000_01CB);
    do_reset(2'h2, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
